// ### hw/sbrg_baud_gen.sv
// Baud rate generator with an AXI4-Lite register port.
`timescale 1ns/1ps
module sbrg_baud_gen
    import sbrg_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              byteBusy,
    output logic                   txRateTick,
    output logic                   rxRateTick,
    output logic                   serialStopped
);

    // ----------------------------------------------------------------
    // Elaboration check.
    // ----------------------------------------------------------------
    if (ADDR_W < 10) begin : g_badAddr
        $error("Address width must reach the highest register.");
    end

    // ----------------------------------------------------------------
    // Declarations.
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] awAddr_q;
    logic              awHeld_q;
    logic [7:0]        wData_q;
    logic              wStrb0_q;
    logic              wHeld_q;
    logic              doWrite;
    logic [7:0]        wIdx;
    logic [7:0]        rIdx;
    logic [7:0]        baudSel_q;
    logic [7:0]        rxFine_q;
    logic [7:0]        txFine_q;
    logic              lowPowerDisable_q;
    logic              run_q;
    logic [1:0]        coarseSel;
    logic [2:0]        txSel;
    logic [2:0]        rxSel;
    logic [3:0]        coarseLoad;
    logic [7:0]        txMul;
    logic [7:0]        rxMul;
    logic [14:0]       txTotal;
    logic [14:0]       rxTotal;
    logic              prescTick;
    logic              sixteenTick;
    logic              wMapped;

    assign coarseSel = baudSel_q[SBRG_COARSE_LSB +: 2];
    assign txSel     = baudSel_q[SBRG_TX_SEL_LSB +: 3];
    assign rxSel     = baudSel_q[SBRG_RX_SEL_LSB +: 3];

    // ----------------------------------------------------------------
    // AXI4-Lite write channel: address and data taken in any order.
    // ----------------------------------------------------------------
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign wIdx          = awAddr_q[9:2];
    assign wMapped = (wIdx == SBRG_IDX_BAUD_SEL) || (wIdx == SBRG_IDX_CONTROL)
                  || (wIdx == SBRG_IDX_RX_FINE) || (wIdx == SBRG_IDX_TX_FINE)
                  || (wIdx == SBRG_IDX_STATUS);

    // Holds the write address until the write is carried out.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    // Holds the write data and its low byte lane strobe.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wHeld_q  <= 1'b0;
            wData_q  <= 8'h00;
            wStrb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q  <= 1'b1;
            wData_q  <= s_axi_wdata[7:0];
            wStrb0_q <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    // Write response one cycle after both halves are held.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SBRG_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wMapped ? SBRG_RESP_OKAY : SBRG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers written by software.
    // ----------------------------------------------------------------
    // Baud rate select register.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            baudSel_q <= SBRG_BAUD_SEL_RST;
        end else if (doWrite && wStrb0_q && wIdx == SBRG_IDX_BAUD_SEL) begin
            baudSel_q <= wData_q;
        end
    end

    // Fine divisors clear to zero at reset.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rxFine_q <= SBRG_FINE_RST;
            txFine_q <= SBRG_FINE_RST;
        end else if (doWrite && wStrb0_q) begin
            if (wIdx == SBRG_IDX_RX_FINE) begin
                rxFine_q <= wData_q;
            end
            if (wIdx == SBRG_IDX_TX_FINE) begin
                txFine_q <= wData_q;
            end
        end
    end

    // Control register holding the low-power disable bit.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lowPowerDisable_q <= SBRG_LPD_RST;
        end else if (doWrite && wStrb0_q && wIdx == SBRG_IDX_CONTROL) begin
            lowPowerDisable_q <= wData_q[SBRG_LPD_BIT];
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel.
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rIdx          = s_axi_araddr[9:2];

    // Read data captured on the address handshake.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= SBRG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= SBRG_RESP_OKAY;
            unique case (rIdx)
                SBRG_IDX_BAUD_SEL: s_axi_rdata <= {24'h000000, baudSel_q};
                SBRG_IDX_CONTROL:  s_axi_rdata <= {31'h0, lowPowerDisable_q};
                SBRG_IDX_RX_FINE:  s_axi_rdata <= {24'h000000, rxFine_q};
                SBRG_IDX_TX_FINE:  s_axi_rdata <= {24'h000000, txFine_q};
                SBRG_IDX_STATUS: begin
                    s_axi_rdata <= {29'h00000000, rxFine_q != 8'h00,
                                    txFine_q != 8'h00, run_q};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= SBRG_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Low-power stop: waits for the byte in transfer to finish.
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            run_q <= 1'b1;
        end else if (lowPowerDisable_q && !byteBusy) begin
            run_q <= 1'b0;
        end else if (!lowPowerDisable_q) begin
            run_q <= 1'b1;
        end
    end

    assign serialStopped = !run_q;

    // ----------------------------------------------------------------
    // Division factors.
    // ----------------------------------------------------------------
    // Coarse prescaler reload from the two-bit select.
    always_comb begin
        unique case (coarseSel)
            2'b00: coarseLoad = SBRG_COARSE_LD_1;
            2'b01: coarseLoad = SBRG_COARSE_LD_3;
            2'b10: coarseLoad = SBRG_COARSE_LD_4;
            2'b11: coarseLoad = SBRG_COARSE_LD_13;
        endcase
    end

    // A zero fine divisor leaves the power of two alone; a power of two
    // times a byte is a shift, which keeps the product small.
    assign txMul   = (txFine_q == 8'h00) ? 8'h01 : txFine_q;
    assign rxMul   = (rxFine_q == 8'h00) ? 8'h01 : rxFine_q;
    assign txTotal = {7'h00, txMul} << txSel;
    assign rxTotal = {7'h00, rxMul} << rxSel;

    // ----------------------------------------------------------------
    // Divider chain: coarse, fixed sixteen, then one stage per side.
    // ----------------------------------------------------------------
    sbrg_div_cnt #(.W(4)) u_coarse (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (run_q),
        .tickIn  (1'b1),
        .loadVal (coarseLoad),
        .tickOut (prescTick)
    );

    sbrg_div_cnt #(.W(4)) u_sixteen (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (run_q),
        .tickIn  (prescTick),
        .loadVal (SBRG_SIXTEEN_LD),
        .tickOut (sixteenTick)
    );

    sbrg_div_cnt #(.W(15)) u_tx (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (run_q),
        .tickIn  (sixteenTick),
        .loadVal (txTotal - 15'h0001),
        .tickOut (txRateTick)
    );

    sbrg_div_cnt #(.W(15)) u_rx (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (run_q),
        .tickIn  (sixteenTick),
        .loadVal (rxTotal - 15'h0001),
        .tickOut (rxRateTick)
    );

    // ----------------------------------------------------------------
    // Checking helpers: count sixteen-ticks between rate pulses.
    // ----------------------------------------------------------------
    logic [14:0] txGap_q;
    logic [14:0] rxGap_q;
    logic [1:0]  txOk_q;
    logic [1:0]  rxOk_q;

    // Gap counters restart on each rate pulse.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            txGap_q <= 15'h0000;
            rxGap_q <= 15'h0000;
        end else begin
            txGap_q <= (txRateTick ? 15'h0000 : txGap_q)
                     + {14'h0000, sixteenTick};
            rxGap_q <= (rxRateTick ? 15'h0000 : rxGap_q)
                     + {14'h0000, sixteenTick};
        end
    end

    // A gap is judged from the third pulse after a change, since the
    // first pulse may still come from a reload made on the write edge.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            txOk_q <= 2'h0;
            rxOk_q <= 2'h0;
        end else if (doWrite || !run_q) begin
            txOk_q <= 2'h0;
            rxOk_q <= 2'h0;
        end else begin
            txOk_q <= txOk_q | {txOk_q[0] && txRateTick, txRateTick};
            rxOk_q <= rxOk_q | {rxOk_q[0] && rxRateTick, rxRateTick};
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    coarse_four_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) prescTick && $past(coarseSel) == 2'b10 |=>
        !prescTick [*3]) else $error("Coarse divide by four ticked early.");
    coarse_one_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) prescTick && $past(coarseSel) == 2'b00
        && run_q |=> prescTick) else $error("Coarse divide by one missed.");
    tx_period_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) txRateTick && txOk_q[1] && txFine_q == 8'h00
        |-> txGap_q == (15'h0001 << txSel)) else $error("Tx period wrong.");
    rx_period_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) rxRateTick && rxOk_q[1] && rxFine_q == 8'h00
        |-> rxGap_q == (15'h0001 << rxSel)) else $error("Rx period wrong.");
    tx_fine_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) txRateTick && txOk_q[1] && txFine_q != 8'h00
        |-> txGap_q == (15'(txFine_q) << txSel)) else $error("Tx fine wrong.");
    rx_fine_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) rxRateTick && rxOk_q[1] && rxFine_q != 8'h00
        |-> rxGap_q == (15'(rxFine_q) << rxSel)) else $error("Rx fine wrong.");
    fine_reset_a: assert property (@(posedge clk_sys)
        $past(sys_rst) && !sys_rst |-> txFine_q == 8'h00 && rxFine_q == 8'h00)
        else $error("Fine divisors not zero after reset.");
    stop_idle_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) lowPowerDisable_q && !byteBusy |=> !run_q ##1
        !txRateTick) else $error("Generator kept running after a stop.");
    stop_wait_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) run_q && byteBusy |=> run_q)
        else $error("Generator stopped inside a byte.");
    halted_out_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) !run_q ##1 !run_q |-> !txRateTick
        && !rxRateTick) else $error("Rate pulse while stopped.");

endmodule // sbrg_baud_gen

// ### hw/sbrg_div_cnt.sv
// Reloading down-counter that divides a tick stream by its loaded value plus one.
`timescale 1ns/1ps
module sbrg_div_cnt #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         run,
    input  wire logic         tickIn,
    input  wire logic [W-1:0] loadVal,
    output logic              tickOut
);

    // ----------------------------------------------------------------
    // Elaboration check.
    // ----------------------------------------------------------------
    if (W < 1) begin : g_badWidth
        $error("Divider width must be at least one bit.");
    end

    logic [W-1:0] cnt_q;

    // Counter reloads from the live setting each time it expires.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (tickIn) begin
            if (cnt_q == '0) begin
                cnt_q <= loadVal;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Output pulse is registered so it never glitches.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tickOut <= 1'b0;
        end else begin
            tickOut <= run && tickIn && (cnt_q == '0);
        end
    end

endmodule // sbrg_div_cnt

// ### include/sbrg_pkg.sv
// Package of constants for the serial baud rate generator.
// What this block does
// - The two-bit coarse select divides the bus clock by 1, 3, 4 or 13 for codes 00, 01, 10 and 11.
// - The three-bit transmit select gives a factor of two to the power of the field, joined with the coarse factor.
// - The three-bit receive select gives a factor of two to the power of the field, joined with the coarse factor.
// - The transmit power-of-two factor stands alone only while the transmit fine divisor is zero, else it is multiplied by it.
// - The receive power-of-two factor stands alone only while the receive fine divisor is zero, else it is multiplied by it.
// - A nonzero receive fine divisor divides the output of the divide-by-16 stage by its value, 1 to 255.
// - A nonzero transmit fine divisor divides the output of the divide-by-16 stage by its value, 1 to 255.
// - After reset both fine divisors read zero, so only the conventional division acts.
// - With the low-power disable bit set, prescalers and outputs stop at the end of the byte in transfer.
package sbrg_pkg;

    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ----------------------------------------------------------------
    localparam logic [7:0] SBRG_IDX_BAUD_SEL = 8'hf2;
    localparam logic [7:0] SBRG_IDX_CONTROL  = 8'hf3;
    localparam logic [7:0] SBRG_IDX_RX_FINE  = 8'hf5;
    localparam logic [7:0] SBRG_IDX_TX_FINE  = 8'hf6;
    localparam logic [7:0] SBRG_IDX_STATUS   = 8'hf7;

    // ----------------------------------------------------------------
    // Field positions inside the baud rate select and control registers.
    // ----------------------------------------------------------------
    localparam int SBRG_COARSE_LSB = 6;
    localparam int SBRG_TX_SEL_LSB = 3;
    localparam int SBRG_RX_SEL_LSB = 0;
    localparam int SBRG_LPD_BIT    = 0;

    // ----------------------------------------------------------------
    // Values after reset.
    // ----------------------------------------------------------------
    localparam logic [7:0] SBRG_BAUD_SEL_RST = 8'h00;
    localparam logic [7:0] SBRG_FINE_RST     = 8'h00;
    localparam logic       SBRG_LPD_RST      = 1'b0;

    // ----------------------------------------------------------------
    // Reload values of the coarse prescaler (factor minus one).
    // ----------------------------------------------------------------
    localparam logic [3:0] SBRG_COARSE_LD_1  = 4'h0;
    localparam logic [3:0] SBRG_COARSE_LD_3  = 4'h2;
    localparam logic [3:0] SBRG_COARSE_LD_4  = 4'h3;
    localparam logic [3:0] SBRG_COARSE_LD_13 = 4'hc;

    // Reload value of the fixed divide-by-16 stage.
    localparam logic [3:0] SBRG_SIXTEEN_LD = 4'hf;

    // ----------------------------------------------------------------
    // Bus answers.
    // ----------------------------------------------------------------
    localparam logic [1:0] SBRG_RESP_OKAY   = 2'b00;
    localparam logic [1:0] SBRG_RESP_SLVERR = 2'b10;

endpackage

// ### test/sbrg_baud_gen_bench.sv
// Self-checking bench of the baud rate generator.
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL %0t got %0h want %0h", $time, (g), (e)); end end
module sbrg_baud_gen_bench;
    import sbrg_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk_sys = 0, sys_rst = 1, startByte = 0;
    logic [11:0] awAddr = 0, arAddr = 0;
    logic [31:0] wData = 0, rData;
    logic [3:0]  wStrb = 0;
    logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0;
    logic        rReady = 0, awReady, wReady, bValid, arReady, rValid;
    logic [1:0]  bResp, rResp, resp;
    logic        byteBusy, txRateTick, rxRateTick, serialStopped;
    logic [31:0] d;
    int          miscompares = 0, nCompared = 0, p, c, ts, rs, tf, rf;
    int          coarseTab [4] = '{1, 3, 4, 13};

    sbrg_baud_gen u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .byteBusy(byteBusy),
        .txRateTick(txRateTick), .rxRateTick(rxRateTick),
        .serialStopped(serialStopped));

    sbrg_shifter_model u_shift (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .startByte(startByte), .txRateTick(txRateTick),
        .byteBusy(byteBusy));

    // The bench clock toggles every 20 ns, half of its 40 ns period.
    always #20 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("compared %0d mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Byte address of a register index.
    function automatic logic [11:0] ra(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    // Bus write; each channel is released once it is taken.
    task automatic wr(input logic [7:0] i, input logic [31:0] v);
        int n;
        logic aw, w;
        aw = 1;
        w = 1;
        awAddr <= ra(i);
        wData <= v;
        wStrb <= 4'hf;
        awValid <= 1;
        wValid <= 1;
        bReady <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (bValid === 1'b1) break;
            if (aw && awReady === 1'b1) begin aw = 0; awValid <= 0; end
            if (w && wReady === 1'b1) begin w = 0; wValid <= 0; end
        end
        resp = bResp;
        bReady <= 0;
        @(posedge clk_sys);  // Keeps back-to-back calls one edge apart.
        if (n == 50) begin miscompares++; complete_run(); end
    endtask

    // Bus read; rready is held until the answer arrives.
    task automatic rd(input logic [11:0] a);
        int n;
        logic ar;
        ar = 1;
        arAddr <= a;
        arValid <= 1;
        rReady <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (rValid === 1'b1) break;
            if (ar && arReady === 1'b1) begin ar = 0; arValid <= 0; end
        end
        d = rData;
        resp = rResp;
        rReady <= 0;
        @(posedge clk_sys);  // Keeps back-to-back calls one edge apart.
        if (n == 50) begin miscompares++; complete_run(); end
    endtask

    // Waits for a rate pulse, skips one rate period, then measures the next one in cycles.
    task automatic meas(input bit tx);
        int n;
        for (int k = 0; k < 3; k++) begin
            for (n = 0; n < 4000; n++) begin
                @(posedge clk_sys);
                if ((tx ? txRateTick : rxRateTick) === 1'b1) break;
            end
            if (n == 4000) begin miscompares++; complete_run(); end
            p = n + 1;
        end
    endtask

    // Rate period expected from coarse, power-of-two and fine factors.
    function automatic int expPer(int cc, int s, int f);
        return coarseTab[cc] * 16 * (1 << s) * (f == 0 ? 1 : f);
    endfunction

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 0;
        @(posedge clk_sys);
        void'($urandom(96));
        // Reset values and a refused address.
        rd(ra(SBRG_IDX_RX_FINE));
        `CHK(d, 32'h0)
        rd(ra(SBRG_IDX_TX_FINE));
        `CHK(d, 32'h0)
        rd(ra(SBRG_IDX_BAUD_SEL));
        `CHK(d, {24'h0, SBRG_BAUD_SEL_RST})
        rd(12'h040);
        `CHK(resp, SBRG_RESP_SLVERR)
        wr(8'h10, 32'h0);
        `CHK(resp, SBRG_RESP_SLVERR)
        meas(1);
        `CHK(p, 16)
        // Every coarse code with random power-of-two and fine factors; the receive fine divisor is zero for code 11.
        for (c = 0; c < 4; c++) begin
            ts = $urandom_range(2);
            rs = $urandom_range(2);
            tf = $urandom_range(3);
            rf = (c == 3) ? 0 : $urandom_range(3);
            wr(SBRG_IDX_BAUD_SEL, 32'((c << 6) | (ts << 3) | rs));
            `CHK(resp, SBRG_RESP_OKAY)
            wr(SBRG_IDX_TX_FINE, 32'(tf));
            wr(SBRG_IDX_RX_FINE, 32'(rf));
            rd(ra(SBRG_IDX_RX_FINE));
            `CHK(d, 32'(rf))
            rd(ra(SBRG_IDX_STATUS));
            `CHK(d, 32'({rf != 0, tf != 0, 1'b1}))
            meas(1);
            `CHK(p, expPer(c, ts, tf))
            meas(0);
            `CHK(p, expPer(c, rs, rf))
        end
        // Low-power stop waits for the byte in flight to end.
        wr(SBRG_IDX_BAUD_SEL, 32'h0);
        wr(SBRG_IDX_TX_FINE, 32'h0);
        startByte <= 1;
        @(posedge clk_sys);
        startByte <= 0;
        wr(SBRG_IDX_CONTROL, 32'h1);
        ts = 0;
        for (c = 0; c < 400 && byteBusy === 1'b1; c++) begin
            if (serialStopped !== 1'b0) ts++;
            @(posedge clk_sys);
        end
        if (c == 400) begin miscompares++; complete_run(); end
        `CHK(ts, 0)
        repeat (2) @(posedge clk_sys);
        `CHK(serialStopped, 1'b1)
        ts = 0;
        repeat (300) begin
            @(posedge clk_sys);
            if (txRateTick !== 1'b0 || rxRateTick !== 1'b0) ts++;
        end
        `CHK(ts, 0)
        rd(ra(SBRG_IDX_CONTROL));
        `CHK(d, 32'h1)
        rd(ra(SBRG_IDX_STATUS));
        `CHK(d, 32'h0)
        wr(SBRG_IDX_CONTROL, 32'h0);
        meas(1);
        `CHK(p, 16)
        complete_run();
    end
endmodule // sbrg_baud_gen_bench

// ### test/sbrg_shifter_model.sv
// Shifter model that frames bytes against the transmit rate clock.
`timescale 1ns/1ps
module sbrg_shifter_model (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic startByte,
    input  wire logic txRateTick,
    output logic      byteBusy
);
    // ----------------------------------------------------------------
    // Bit counting
    // ----------------------------------------------------------------
    int bitsLeft;

    // A byte frame lasts ten transmit rate periods.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bitsLeft <= 0;
        end else if (startByte && bitsLeft == 0) begin
            bitsLeft <= 10;
        end else if (txRateTick && bitsLeft != 0) begin
            bitsLeft <= bitsLeft - 1;
        end
    end

    // Busy stays high for the whole frame.
    assign byteBusy = (bitsLeft != 0);
endmodule // sbrg_shifter_model
